// ==== include/logic_eq_pkg.sv ====
package logic_eq_pkg;
  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int N_EQ = 16;
  localparam int EQ_IDX_W = 4;
  localparam int N_CONTACT = 8;
  localparam int N_FORM_A = 4;
  localparam int N_ELEM = 4;
  localparam int N_COUNTER = 2;
  localparam int N_DIRECT = 8;
  localparam int N_REMOTE = 8;
  localparam int N_SOFT = 8;
  localparam int SEL_W = 7;
  localparam int DELAY_W = 8;
  localparam int COUNT_W = 16;
  localparam int N_OPERAND = 92;
  localparam int N_SYNC = N_CONTACT + 2 * N_FORM_A + N_DIRECT + N_REMOTE + N_SOFT + N_COUNTER;

  // ---------------------------------------------------------------
  // equation word layout
  // ---------------------------------------------------------------
  localparam int OPC_W = 3;
  localparam int EQ_W = 26;
  localparam int F_OPC_LSB = 23;
  localparam int F_INV_A = 22;
  localparam int F_INV_B = 21;
  localparam int F_SEL_A_LSB = 14;
  localparam int F_SEL_B_LSB = 7;
  localparam int F_PRESET_LSB = 0;

  // operator codes
  localparam logic [2:0] OPC_AND = 3'h0;
  localparam logic [2:0] OPC_OR = 3'h1;
  localparam logic [2:0] OPC_XOR = 3'h2;
  localparam logic [2:0] OPC_LATCH = 3'h3;
  localparam logic [2:0] OPC_TIMER = 3'h4;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [N_EQ-1:0] FLAGS_RESET = 16'h0000;
  localparam logic [EQ_W-1:0] EQ_RESET = 26'h0000000;
  localparam logic [DELAY_W-1:0] DELAY_RESET = 8'h00;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLOCK_MHZ = 200;
  localparam int PASS_INTERVAL_US = 1000;
  localparam int PASS_CYCLES = PASS_INTERVAL_US * CLOCK_MHZ;
  localparam int PASS_CNT_W = 24;

  // sequencer states
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_FETCH = 3'b010,
    SEQ_EVAL = 3'b100
  } seq_state_t;
endpackage : logic_eq_pkg

// ==== logic/equation_memory.sv ====
module equation_memory (
  // clock
  input wire logic clock,
  // program write port
  input wire logic wr_en,
  input wire logic [logic_eq_pkg::EQ_IDX_W-1:0] wr_addr,
  input wire logic [logic_eq_pkg::EQ_W-1:0] wr_data,
  // read port
  input wire logic [logic_eq_pkg::EQ_IDX_W-1:0] rd_addr,
  output logic [logic_eq_pkg::EQ_W-1:0] rd_data
);
  logic [logic_eq_pkg::EQ_W-1:0] words [logic_eq_pkg::N_EQ];

  // store and registered read
  always_ff @(posedge clock) begin
    if (wr_en) begin
      words[wr_addr] <= wr_data;
    end
    rd_data <= words[rd_addr];
  end
endmodule : equation_memory

// ==== logic/digital_element.sv ====
module digital_element (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // timebase and input
  input wire logic tick,
  input wire logic level,
  // delays in evaluation ticks
  input wire logic [logic_eq_pkg::DELAY_W-1:0] pickup_delay,
  input wire logic [logic_eq_pkg::DELAY_W-1:0] reset_delay,
  // element operands
  output logic element_pickup,
  output logic element_dropout,
  output logic element_operate
);
  logic [logic_eq_pkg::DELAY_W-1:0] tcnt;
  logic [logic_eq_pkg::DELAY_W-1:0] next_tcnt;
  logic next_operate;

  // pickup and reset timing
  always_comb begin
    next_operate = element_operate;
    next_tcnt = tcnt;
    if (!element_operate) begin
      if (!level) begin
        next_tcnt = logic_eq_pkg::DELAY_RESET;
      end else if (tcnt >= pickup_delay) begin
        next_operate = 1'b1;
        next_tcnt = logic_eq_pkg::DELAY_RESET;
      end else if (tick) begin
        next_tcnt = tcnt + 8'h01;
      end
    end else begin
      if (level) begin
        next_tcnt = logic_eq_pkg::DELAY_RESET;
      end else if (tcnt >= reset_delay) begin
        next_operate = 1'b0;
        next_tcnt = logic_eq_pkg::DELAY_RESET;
      end else if (tick) begin
        next_tcnt = tcnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      tcnt <= logic_eq_pkg::DELAY_RESET;
      element_operate <= 1'b0;
      element_pickup <= 1'b0;
      element_dropout <= 1'b1;
    end else begin
      tcnt <= next_tcnt;
      element_operate <= next_operate;
      element_pickup <= level;
      element_dropout <= ~level;
    end
  end
endmodule : digital_element

// ==== logic/logic_equation_engine.sv ====
module logic_equation_engine #(
  parameter int PASS_CYCLES = logic_eq_pkg::PASS_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // equation program port
  input wire logic prog_we,
  input wire logic [logic_eq_pkg::EQ_IDX_W-1:0] prog_addr,
  input wire logic [logic_eq_pkg::EQ_W-1:0] prog_data,
  // field inputs
  input wire logic [logic_eq_pkg::N_CONTACT-1:0] contact_in,
  input wire logic [logic_eq_pkg::N_FORM_A-1:0] contact_voltage_sense,
  input wire logic [logic_eq_pkg::N_FORM_A-1:0] contact_current_sense,
  input wire logic [logic_eq_pkg::N_DIRECT-1:0] direct_in,
  input wire logic [logic_eq_pkg::N_REMOTE-1:0] remote_in,
  input wire logic [logic_eq_pkg::N_SOFT-1:0] soft_input_flag,
  input wire logic [logic_eq_pkg::N_COUNTER-1:0] count_pulse,
  // element configuration
  input wire logic [logic_eq_pkg::N_ELEM*logic_eq_pkg::SEL_W-1:0] elem_sel,
  input wire logic [logic_eq_pkg::N_ELEM*logic_eq_pkg::DELAY_W-1:0] elem_pickup_delay,
  input wire logic [logic_eq_pkg::N_ELEM*logic_eq_pkg::DELAY_W-1:0] elem_reset_delay,
  // counter configuration
  input wire logic [logic_eq_pkg::N_COUNTER*logic_eq_pkg::COUNT_W-1:0] count_setpoint,
  input wire logic [logic_eq_pkg::N_COUNTER-1:0] count_clear,
  // results
  output logic [logic_eq_pkg::N_EQ-1:0] equation_result_flag,
  output logic pass_done,
  output logic busy,
  // communication port copies
  output logic [logic_eq_pkg::N_EQ-1:0] comm_result_flags,
  output logic [logic_eq_pkg::N_SOFT-1:0] comm_soft_inputs
);
  // -----------------------------------------------------------------
  // operand selection
  // -----------------------------------------------------------------
  function automatic logic operand_at(
    input logic [logic_eq_pkg::N_OPERAND-1:0] vec,
    input logic [logic_eq_pkg::SEL_W-1:0] idx
  );
    logic bit_val;
    bit_val = 1'b0;
    if (int'(idx) < logic_eq_pkg::N_OPERAND) begin
      bit_val = vec[idx];
    end
    return bit_val;
  endfunction : operand_at

  // -----------------------------------------------------------------
  // input synchronisers
  // -----------------------------------------------------------------
  logic [logic_eq_pkg::N_SYNC-1:0] sync_a;
  logic [logic_eq_pkg::N_SYNC-1:0] sync_b;
  logic [logic_eq_pkg::N_SYNC-1:0] raw_in;

  assign raw_in = {count_pulse, soft_input_flag, remote_in, direct_in,
                   contact_current_sense, contact_voltage_sense, contact_in};

  // two flops per field input
  always_ff @(posedge clock) begin
    if (rst) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= raw_in;
      sync_b <= sync_a;
    end
  end

  logic [logic_eq_pkg::N_CONTACT-1:0] contact_s;
  logic [logic_eq_pkg::N_FORM_A-1:0] volt_s;
  logic [logic_eq_pkg::N_FORM_A-1:0] curr_s;
  logic [logic_eq_pkg::N_DIRECT-1:0] direct_s;
  logic [logic_eq_pkg::N_REMOTE-1:0] remote_s;
  logic [logic_eq_pkg::N_SOFT-1:0] soft_s;
  logic [logic_eq_pkg::N_COUNTER-1:0] pulse_s;

  assign {pulse_s, soft_s, remote_s, direct_s, curr_s, volt_s, contact_s} = sync_b;

  // -----------------------------------------------------------------
  // pass timebase
  // -----------------------------------------------------------------
  logic [logic_eq_pkg::PASS_CNT_W-1:0] pass_cnt;
  logic [logic_eq_pkg::PASS_CNT_W-1:0] next_pass_cnt;
  logic tick;

  always_comb begin
    tick = (pass_cnt == logic_eq_pkg::PASS_CNT_W'(PASS_CYCLES - 1));
    next_pass_cnt = tick ? '0 : pass_cnt + 24'h000001;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pass_cnt <= '0;
    end else begin
      pass_cnt <= next_pass_cnt;
    end
  end

  // -----------------------------------------------------------------
  // digital elements
  // -----------------------------------------------------------------
  logic [logic_eq_pkg::N_ELEM-1:0] element_pickup;
  logic [logic_eq_pkg::N_ELEM-1:0] element_dropout;
  logic [logic_eq_pkg::N_ELEM-1:0] element_operate;
  logic [logic_eq_pkg::N_OPERAND-1:0] operands;

  generate
    for (genvar e = 0; e < logic_eq_pkg::N_ELEM; e++) begin : g_elem
      digital_element u_elem (
        .clock(clock),
        .rst(rst),
        .tick(tick),
        .level(operand_at(operands, elem_sel[e*logic_eq_pkg::SEL_W +: logic_eq_pkg::SEL_W])),
        .pickup_delay(elem_pickup_delay[e*logic_eq_pkg::DELAY_W +: logic_eq_pkg::DELAY_W]),
        .reset_delay(elem_reset_delay[e*logic_eq_pkg::DELAY_W +: logic_eq_pkg::DELAY_W]),
        .element_pickup(element_pickup[e]),
        .element_dropout(element_dropout[e]),
        .element_operate(element_operate[e])
      );
    end
  endgenerate

  // -----------------------------------------------------------------
  // digital counters
  // -----------------------------------------------------------------
  logic [logic_eq_pkg::COUNT_W-1:0] count [logic_eq_pkg::N_COUNTER];
  logic [logic_eq_pkg::COUNT_W-1:0] next_count [logic_eq_pkg::N_COUNTER];
  logic [logic_eq_pkg::N_COUNTER-1:0] pulse_prev;
  logic [logic_eq_pkg::N_COUNTER-1:0] count_above;
  logic [logic_eq_pkg::N_COUNTER-1:0] count_equal;
  logic [logic_eq_pkg::N_COUNTER-1:0] count_below;
  logic [logic_eq_pkg::N_COUNTER-1:0] next_above;
  logic [logic_eq_pkg::N_COUNTER-1:0] next_equal;
  logic [logic_eq_pkg::N_COUNTER-1:0] next_below;

  // count rising edges, compare with setpoint
  always_comb begin
    for (int c = 0; c < logic_eq_pkg::N_COUNTER; c++) begin
      if (count_clear[c]) begin
        next_count[c] = logic_eq_pkg::COUNT_RESET;
      end else if (pulse_s[c] && !pulse_prev[c]) begin
        next_count[c] = count[c] + 16'h0001;
      end else begin
        next_count[c] = count[c];
      end
      next_above[c] = count[c] > count_setpoint[c*logic_eq_pkg::COUNT_W +: logic_eq_pkg::COUNT_W];
      next_equal[c] = count[c] == count_setpoint[c*logic_eq_pkg::COUNT_W +: logic_eq_pkg::COUNT_W];
      next_below[c] = count[c] < count_setpoint[c*logic_eq_pkg::COUNT_W +: logic_eq_pkg::COUNT_W];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      for (int c = 0; c < logic_eq_pkg::N_COUNTER; c++) begin
        count[c] <= logic_eq_pkg::COUNT_RESET;
      end
      pulse_prev <= '0;
      count_above <= '0;
      count_equal <= '1;
      count_below <= '0;
    end else begin
      count <= next_count;
      pulse_prev <= pulse_s;
      count_above <= next_above;
      count_equal <= next_equal;
      count_below <= next_below;
    end
  end

  // -----------------------------------------------------------------
  // operand vector
  // -----------------------------------------------------------------
  // single-bit operands
  assign operands = {equation_result_flag, soft_s, remote_s, direct_s,
                     count_below, count_equal, count_above,
                     element_operate, element_dropout, element_pickup,
                     ~curr_s, curr_s, ~volt_s, volt_s,
                     ~contact_s, contact_s, 1'b1, 1'b0};

  // -----------------------------------------------------------------
  // equation store
  // -----------------------------------------------------------------
  logic [logic_eq_pkg::EQ_IDX_W-1:0] eq_idx;
  logic [logic_eq_pkg::EQ_W-1:0] eq_word;

  equation_memory u_mem (
    .clock(clock),
    .wr_en(prog_we),
    .wr_addr(prog_addr),
    .wr_data(prog_data),
    .rd_addr(eq_idx),
    .rd_data(eq_word)
  );

  // -----------------------------------------------------------------
  // sequencer and evaluation
  // -----------------------------------------------------------------
  logic_eq_pkg::seq_state_t state;
  logic_eq_pkg::seq_state_t next_state;
  logic [logic_eq_pkg::EQ_IDX_W-1:0] next_eq_idx;
  logic [logic_eq_pkg::N_EQ-1:0] next_flags;
  logic [logic_eq_pkg::DELAY_W-1:0] timer_cnt [logic_eq_pkg::N_EQ];
  logic [logic_eq_pkg::DELAY_W-1:0] next_timer_cnt [logic_eq_pkg::N_EQ];
  logic next_pass_done;
  logic opd_a;
  logic opd_b;
  logic result;
  logic [logic_eq_pkg::OPC_W-1:0] opc;
  logic [logic_eq_pkg::DELAY_W-1:0] preset;

  assign opc = eq_word[logic_eq_pkg::F_OPC_LSB +: logic_eq_pkg::OPC_W];
  assign preset = eq_word[logic_eq_pkg::F_PRESET_LSB +: logic_eq_pkg::DELAY_W];

  // one equation per two cycles
  always_comb begin
    next_state = state;
    next_eq_idx = eq_idx;
    next_flags = equation_result_flag;
    next_timer_cnt = timer_cnt;
    next_pass_done = 1'b0;
    result = 1'b0;
    opd_a = operand_at(operands, eq_word[logic_eq_pkg::F_SEL_A_LSB +: logic_eq_pkg::SEL_W])
            ^ eq_word[logic_eq_pkg::F_INV_A];
    opd_b = operand_at(operands, eq_word[logic_eq_pkg::F_SEL_B_LSB +: logic_eq_pkg::SEL_W])
            ^ eq_word[logic_eq_pkg::F_INV_B];
    case (opc)
      logic_eq_pkg::OPC_AND: result = opd_a & opd_b;
      logic_eq_pkg::OPC_OR: result = opd_a | opd_b;
      logic_eq_pkg::OPC_XOR: result = opd_a ^ opd_b;
      logic_eq_pkg::OPC_LATCH: result = (opd_a | equation_result_flag[eq_idx]) & ~opd_b;
      logic_eq_pkg::OPC_TIMER: result = opd_a && (timer_cnt[eq_idx] >= preset);
      default: result = 1'b0; // unused codes give zero
    endcase
    unique case (state)
      logic_eq_pkg::SEQ_IDLE: begin
        next_eq_idx = '0;
        if (tick) begin
          next_state = logic_eq_pkg::SEQ_FETCH;
        end
      end
      logic_eq_pkg::SEQ_FETCH: begin
        next_state = logic_eq_pkg::SEQ_EVAL;
      end
      logic_eq_pkg::SEQ_EVAL: begin
        next_flags[eq_idx] = result;
        if (opc == logic_eq_pkg::OPC_TIMER) begin
          if (!opd_a) begin
            next_timer_cnt[eq_idx] = logic_eq_pkg::DELAY_RESET;
          end else if (timer_cnt[eq_idx] < preset) begin
            next_timer_cnt[eq_idx] = timer_cnt[eq_idx] + 8'h01;
          end
        end
        if (eq_idx == logic_eq_pkg::EQ_IDX_W'(logic_eq_pkg::N_EQ - 1)) begin
          next_state = logic_eq_pkg::SEQ_IDLE;
          next_pass_done = 1'b1;
        end else begin
          next_eq_idx = eq_idx + 4'h1;
          next_state = logic_eq_pkg::SEQ_FETCH;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state <= logic_eq_pkg::SEQ_IDLE;
      eq_idx <= '0;
      equation_result_flag <= logic_eq_pkg::FLAGS_RESET;
      for (int i = 0; i < logic_eq_pkg::N_EQ; i++) begin
        timer_cnt[i] <= logic_eq_pkg::DELAY_RESET;
      end
      pass_done <= 1'b0;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      eq_idx <= next_eq_idx;
      equation_result_flag <= next_flags;
      timer_cnt <= next_timer_cnt;
      pass_done <= next_pass_done;
      busy <= (next_state != logic_eq_pkg::SEQ_IDLE);
    end
  end

  // -----------------------------------------------------------------
  // communication port copies
  // -----------------------------------------------------------------
  // shared with peers
  always_ff @(posedge clock) begin
    if (rst) begin
      comm_result_flags <= logic_eq_pkg::FLAGS_RESET;
      comm_soft_inputs <= '0;
    end else begin
      comm_result_flags <= equation_result_flag;
      comm_soft_inputs <= soft_s;
    end
  end
endmodule : logic_equation_engine

// ==== verif/logic_equation_engine_chk.sv ====
module logic_equation_engine_chk #(
  parameter int PASS_CYCLES = logic_eq_pkg::PASS_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // watched ports
  input wire logic [logic_eq_pkg::N_SOFT-1:0] soft_input_flag,
  input wire logic [logic_eq_pkg::N_EQ-1:0] equation_result_flag,
  input wire logic pass_done,
  input wire logic busy,
  input wire logic [logic_eq_pkg::N_EQ-1:0] comm_result_flags,
  input wire logic [logic_eq_pkg::N_SOFT-1:0] comm_soft_inputs
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle gap between passes
  localparam int GAP_MIN = PASS_CYCLES - 33;
  localparam int GAP_MAX = PASS_CYCLES - 31;

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // one pass: busy runs on, then a lone done
  sequence s_busy_run; ##31 busy; endsequence
  sequence s_pass_end; ##1 (pass_done && !busy); endsequence

  property p_pass_len; $rose(busy) |-> s_busy_run ##0 s_pass_end; endproperty
  a_pass_len: assert property (p_pass_len) else $error("pass length wrong");
  property p_pass_gap; pass_done |-> ##[GAP_MIN:GAP_MAX] $rose(busy); endproperty
  a_pass_gap: assert property (p_pass_gap) else $error("pass spacing wrong");
  property p_done_once; pass_done |=> (!pass_done && !busy) [*4]; endproperty
  a_done_once: assert property (p_done_once) else $error("done not a pulse");
  property p_flags_hold; (!busy && !pass_done) |-> $stable(equation_result_flag); endproperty
  a_flags_hold: assert property (p_flags_hold) else $error("flag moved outside pass");
  property p_first_eq; $changed(equation_result_flag[0]) |-> $past(busy, 2) && !$past(busy, 3); endproperty
  a_first_eq: assert property (p_first_eq) else $error("flag 0 at wrong time");
  property p_last_eq; $changed(equation_result_flag[15]) |-> pass_done; endproperty
  a_last_eq: assert property (p_last_eq) else $error("flag 15 at wrong time");
  property p_comm_flags; comm_result_flags == $past(equation_result_flag); endproperty
  a_comm_flags: assert property (p_comm_flags) else $error("comm flags wrong");
  property p_comm_soft; comm_soft_inputs == $past(soft_input_flag, 3); endproperty
  a_comm_soft: assert property (p_comm_soft) else $error("comm soft wrong");
  property p_reset_state; $fell(rst) |-> equation_result_flag == logic_eq_pkg::FLAGS_RESET && !busy; endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong");
endmodule : logic_equation_engine_chk

bind logic_equation_engine logic_equation_engine_chk #(.PASS_CYCLES(PASS_CYCLES)) chk (
  .clock(clock), .rst(rst), .soft_input_flag(soft_input_flag), .equation_result_flag(equation_result_flag),
  .pass_done(pass_done), .busy(busy), .comm_result_flags(comm_result_flags), .comm_soft_inputs(comm_soft_inputs));

// ==== verif/field_model.sv ====
module field_model (
  // clock
  input wire logic clock,
  // wanted field levels
  input wire logic [41:0] scene,
  // levels at the pins
  output logic [7:0] contact_in,
  output logic [3:0] contact_voltage_sense,
  output logic [3:0] contact_current_sense,
  output logic [7:0] direct_in,
  output logic [7:0] remote_in,
  output logic [7:0] soft_input_flag,
  output logic [1:0] count_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [41:0] lvl = '0;
  // field settles one cycle after a change
  always @(posedge clock) lvl <= scene;
  assign contact_in = lvl[7:0];
  assign contact_voltage_sense = lvl[11:8];
  assign contact_current_sense = lvl[15:12];
  assign direct_in = lvl[23:16];
  assign remote_in = lvl[31:24];
  assign soft_input_flag = lvl[39:32];
  assign count_pulse = lvl[41:40];
endmodule : field_model

// ==== verif/test_logic_equation_engine.sv ====
module test_logic_equation_engine;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rst, prog_we, pass_done, busy;
  logic [3:0] prog_addr;
  logic [25:0] prog_data;
  logic [41:0] scene;
  logic [27:0] elem_sel;
  logic [31:0] pk_dly, rs_dly, count_setpoint;
  logic [1:0] count_clear, count_pulse;
  logic [7:0] contact_in, direct_in, remote_in, soft_input_flag, comm_soft_inputs;
  logic [3:0] contact_voltage_sense, contact_current_sense;
  logic [15:0] equation_result_flag, comm_result_flags, exp;
  int n_fail, cmp_count;

  field_model far (.clock(clock), .scene(scene), .contact_in(contact_in),
    .contact_voltage_sense(contact_voltage_sense), .contact_current_sense(contact_current_sense),
    .direct_in(direct_in), .remote_in(remote_in), .soft_input_flag(soft_input_flag), .count_pulse(count_pulse));
  logic_equation_engine #(.PASS_CYCLES(40)) dut (.clock(clock), .rst(rst), .prog_we(prog_we),
    .prog_addr(prog_addr), .prog_data(prog_data), .contact_in(contact_in),
    .contact_voltage_sense(contact_voltage_sense), .contact_current_sense(contact_current_sense),
    .direct_in(direct_in), .remote_in(remote_in), .soft_input_flag(soft_input_flag),
    .count_pulse(count_pulse), .elem_sel(elem_sel), .elem_pickup_delay(pk_dly), .elem_reset_delay(rs_dly),
    .count_setpoint(count_setpoint), .count_clear(count_clear), .equation_result_flag(equation_result_flag),
    .pass_done(pass_done), .busy(busy), .comm_result_flags(comm_result_flags),
    .comm_soft_inputs(comm_soft_inputs));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    cmp_count++;
    if (seen !== want) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  task automatic do_reset(input int n);
    @(posedge clock);
    scene <= '0;
    rst <= 1'b1;
    repeat (n) @(posedge clock);
    rst <= 1'b0;
  endtask : do_reset

  task automatic prog(input int a, input logic [25:0] w);
    @(posedge clock);
    prog_we <= 1'b1;
    prog_addr <= a[3:0];
    prog_data <= w;
    @(posedge clock);
    prog_we <= 1'b0;
  endtask : prog

  // wait for the end of a pass, bounded
  task automatic wait_pass;
    int n;
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (pass_done !== 1'b1 && n < 300);
    if (n >= 300) check(1'b0, 1'b1);
  endtask : wait_pass

  // random equation word, operate operands left out
  function automatic logic [25:0] rnd_word(input logic [2:0] opc);
    int a, b;
    a = $urandom % 96;
    b = $urandom % 96;
    if (a inside {[42:45]}) a = a - 8;
    if (b inside {[42:45]}) b = b - 8;
    if (opc == logic_eq_pkg::OPC_TIMER) b = b & 94;
    return {opc, 2'($urandom), 7'(a), 7'(b), opc == logic_eq_pkg::OPC_TIMER ? 7'h00 : 7'($urandom)};
  endfunction : rnd_word

  // one pass in order, later equations seen from before
  function automatic logic [15:0] eval_pass(input logic [15:0] f, input logic [25:0] m [16]);
    logic [95:0] v;
    logic [1:0] z;
    logic a, b;
    z = {count_setpoint[31:16] == 16'h0000, count_setpoint[15:0] == 16'h0000};
    for (int k = 0; k < 16; k++) begin
      v = {4'h0, f, scene[39:16], ~z, z, 2'h0, 4'h0, ~scene[3:0], scene[3:0], ~scene[15:12], scene[15:12],
        ~scene[11:8], scene[11:8], ~scene[7:0], scene[7:0], 2'h2};
      a = v[m[k][20:14]] ^ m[k][22];
      b = v[m[k][13:7]] ^ m[k][21];
      case (m[k][25:23])
        3'h0: f[k] = a & b;
        3'h1: f[k] = a | b;
        3'h2: f[k] = a ^ b;
        3'h3: f[k] = (a | f[k]) & ~b;
        3'h4: f[k] = a;
        default: f[k] = 1'b0;
      endcase
    end
    return f;
  endfunction : eval_pass

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  initial begin
    #100000;
    check(1'b0, 1'b1);
    finish_test;
  end

  initial begin
    logic [25:0] mem [16];
    rst = 1'b1;
    prog_we = 1'b0;
    prog_addr = 4'h0;
    prog_data = 26'h0000000;
    scene = '0;
    elem_sel = {7'h05, 7'h04, 7'h03, 7'h02};
    pk_dly = 32'h00000000;
    rs_dly = 32'h00000000;
    count_setpoint = 32'h00000000;
    count_clear = 2'h3;
    n_fail = 0;
    cmp_count = 0;
    void'($urandom(32'hA418));
    do_reset(20);
    // random programs over random field states, feedback included
    for (int t = 0; t < 6; t++) begin
      do_reset(5);
      scene <= {2'h0, 8'($urandom), $urandom};
      pk_dly <= $urandom;
      rs_dly <= $urandom;
      count_setpoint <= {16'($urandom % 2), 16'($urandom % 2)};
      for (int k = 0; k < 16; k++) begin
        mem[k] = rnd_word(3'($urandom));
        prog(k, mem[k]);
      end
      exp = 16'h0000;
      repeat (3) begin
        wait_pass;
        exp = eval_pass(exp, mem);
        check(equation_result_flag, exp);
      end
      @(posedge clock);
      #1;
      check(comm_result_flags, exp);
      check(16'(comm_soft_inputs), 16'(scene[39:32]));
      $display("random test %0d done", t);
    end
    // element operate delays, timer preset, pickup against dropout
    do_reset(5);
    pk_dly <= 32'h00000002;
    rs_dly <= 32'h00000002;
    prog(0, {logic_eq_pkg::OPC_OR, 2'h0, 7'h2A, 7'h00, 7'h00});
    prog(1, {logic_eq_pkg::OPC_TIMER, 2'h0, 7'h03, 7'h00, 7'h03});
    prog(2, {logic_eq_pkg::OPC_XOR, 2'h0, 7'h22, 7'h26, 7'h00});
    wait_pass;
    @(posedge clock);
    scene[1:0] <= 2'h3;
    wait_pass;
    check(16'(equation_result_flag[2:0]), 16'h0004);
    repeat (4) wait_pass;
    check(16'(equation_result_flag[2:0]), 16'h0007);
    @(posedge clock);
    scene[1:0] <= 2'h0;
    wait_pass;
    check(16'(equation_result_flag[2:0]), 16'h0005);
    repeat (4) wait_pass;
    check(16'(equation_result_flag[2:0]), 16'h0004);
    $display("delay test done");
    // counter against set number two
    do_reset(5);
    prog(0, {logic_eq_pkg::OPC_OR, 2'h0, 7'h2E, 7'h00, 7'h00});
    prog(1, {logic_eq_pkg::OPC_OR, 2'h0, 7'h30, 7'h00, 7'h00});
    prog(2, {logic_eq_pkg::OPC_OR, 2'h0, 7'h32, 7'h00, 7'h00});
    count_setpoint <= 32'h00000002;
    count_clear <= 2'h0;
    for (int k = 0; k < 4; k++) begin
      repeat (2) wait_pass;
      check(16'(equation_result_flag[2:0]), (k > 2) ? 16'h0001 : (k == 2) ? 16'h0002 : 16'h0004);
      @(posedge clock);
      scene[40] <= 1'b1;
      repeat (4) @(posedge clock);
      scene[40] <= 1'b0;
    end
    $display("counter test done");
    finish_test;
  end
endmodule : test_logic_equation_engine
